/* File: design/csp_pkg.sv */
// Constants shared by the CPU status and pointer register block.
// Assumes an 8-bit special-function register space and one core clock.
package csp_pkg;

    // -----------------------------------------------------------------
    // Special-function register offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] SFR_PTR_A_LO = 8'h82;
    localparam logic [7:0] SFR_PTR_A_HI = 8'h83;
    localparam logic [7:0] SFR_PTR_B_LO = 8'h84;
    localparam logic [7:0] SFR_PTR_B_HI = 8'h85;
    localparam logic [7:0] SFR_PTR_SEL = 8'h92;
    localparam logic [7:0] SFR_ARB_CTRL = 8'hC7;
    localparam logic [7:0] SFR_PSW = 8'hD0;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int ARB_CACHE_OFF = 1;
    localparam int ARB_PREF_OFF = 0;
    localparam int SEL_PTR = 0;
    localparam int PSW_CARRY = 7;
    localparam int PSW_HALF = 6;
    localparam int PSW_USER_A = 5;
    localparam int PSW_BANK_HI = 4;
    localparam int PSW_BANK_LO = 3;
    localparam int PSW_OVF = 2;
    localparam int PSW_USER_B = 1;
    localparam int PSW_PARITY = 0;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] ARB_RESET = 8'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;

    // -----------------------------------------------------------------
    // General register bank windows
    // -----------------------------------------------------------------
    localparam logic [15:0] BANK_DATA_BASE = 16'h0000;
    localparam logic [15:0] BANK_DATA_LAST = 16'h001F;
    localparam logic [15:0] BANK_UNI_BASE = 16'hFF00;
    localparam logic [15:0] BANK_UNI_LAST = 16'hFF1F;
    localparam int BANK_COUNT = 4;
    localparam int BANK_REGS = 8;
    localparam int PREFETCH_BYTES = 2;

endpackage

/* File: design/csp_ptr_if.sv */
// Write path and value of one 16-bit data pointer.
// Assumes the driver and the register share one clock.
`timescale 1ns/1ps
interface csp_ptr_if;
    logic wr_lo;
    logic wr_hi;
    logic [15:0] wdata;
    logic [15:0] value;

    modport drv (output wr_lo, output wr_hi, output wdata, input value);
    modport store (input wr_lo, input wr_hi, input wdata, output value);
endinterface

/* File: design/csp_ptr_reg.sv */
// One data pointer: low and high byte, each loaded on its own strobe.
// Assumes strobes are single-cycle requests on ref_clk.
`timescale 1ns/1ps
module csp_ptr_reg
    import csp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    csp_ptr_if.store port_if
);
    logic [15:0] value;
    logic [15:0] next_value;

    // Byte lanes load independently
    always_comb begin
        next_value = value;
        if (port_if.wr_lo) begin
            next_value[7:0] = port_if.wdata[7:0];
        end
        if (port_if.wr_hi) begin
            next_value[15:8] = port_if.wdata[15:8];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= {PTR_RESET, PTR_RESET};
        end else begin
            value <= next_value;
        end
    end

    assign port_if.value = value;
endmodule

/* File: design/csp_bank_ram.sv */
// Flip-flop storage for the general register banks.
// One write port, two combinational read ports.
`timescale 1ns/1ps
module csp_bank_ram
    import csp_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [7:0] rdata_b
);
    logic [7:0] mem [DEPTH];
    logic [7:0] next_mem [DEPTH];

    // Write one location, keep the rest
    always_comb begin
        next_mem = mem;
        if (we) begin
            next_mem[waddr] = wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= BANK_RESET;
            end
        end else begin
            mem <= next_mem;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule

/* File: design/csp_regs.sv */
// CPU status word, data pointers, register banks and arbiter control.
// Assumes the execution datapath and SFR access run on ref_clk.
//
// Behaviour
// RULE1: Cache-off bit invalidates cache, bypasses it
// RULE2: Prefetch two bytes after last cached byte
// RULE3: Two zero-reset 16-bit pointers, byte access
// RULE4: Select bit picks pointer for instructions
// RULE5: Four eight-register banks at 0x00-0x1F
// RULE6: Same banks alias at 0xFF00-0xFF1F
// RULE7: Status bits 4:3 choose active bank
// RULE8: Status word byte and bit writable
// RULE9: Carry set on carry or borrow
// RULE10: Half carry follows nibble carry
// RULE11: Overflow from carry, borrow, multiply, divide
// RULE12: Two user flags untouched by hardware
// RULE13: Parity flag shows odd accumulator ones
// RULE14: Accumulator value drives parity flag
// RULE15: Software status writes act like hardware
// RULE16: Parity writes by software do not last
`timescale 1ns/1ps
module csp_regs
    import csp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [2:0] sfr_bit_idx,
    input wire logic sfr_bit_val,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic alu_upd,
    input wire logic alu_upd_cy,
    input wire logic alu_upd_ac,
    input wire logic alu_upd_ov,
    input wire logic alu_cy,
    input wire logic alu_ac,
    input wire logic alu_ov,
    input wire logic [7:0] acc_value,
    input wire logic dp_wr,
    input wire logic [15:0] dp_wdata,
    output logic [15:0] ptr_a,
    output logic [15:0] ptr_b,
    output logic ptr_sel,
    output logic [7:0] program_status_word,
    input wire logic gp_req,
    input wire logic gp_uni,
    input wire logic gp_wr,
    input wire logic [15:0] gp_addr,
    input wire logic [7:0] gp_wdata,
    output logic [7:0] gp_rdata,
    output logic gp_hit,
    input wire logic rn_req,
    input wire logic rn_wr,
    input wire logic [2:0] rn_idx,
    input wire logic [7:0] rn_wdata,
    output logic [7:0] rn_rdata,
    input wire logic fetch_last_byte,
    output logic cache_off,
    output logic prefetch_off,
    output logic cache_invalidate,
    output logic prefetch_req
);
    // -----------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------
    logic [7:0] arb_ctrl;
    logic [7:0] next_arb_ctrl;
    logic [7:0] sel_reg;
    logic [7:0] next_sel_reg;
    logic [7:0] next_psw;
    logic [7:0] next_sfr_rdata;
    logic next_cache_invalidate;
    logic next_prefetch_req;
    logic [7:0] next_gp_rdata;
    logic next_gp_hit;
    logic [7:0] next_rn_rdata;
    logic psw_sw_wr;
    logic ram_we;
    logic [4:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [4:0] gp_idx;
    logic gp_in_range;
    logic [4:0] rn_addr;
    logic [7:0] ram_gp_q;
    logic [7:0] ram_rn_q;

    csp_ptr_if pa_if ();
    csp_ptr_if pb_if ();

    // -----------------------------------------------------------------
    // Data pointers
    // -----------------------------------------------------------------
    csp_ptr_reg u_ptr_a (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .port_if(pa_if.store)
    );

    csp_ptr_reg u_ptr_b (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .port_if(pb_if.store)
    );

    // RULE3: byte access to each pointer
    // RULE4: instruction writes go to selected pointer
    always_comb begin
        pa_if.wr_lo = sfr_wr && sfr_addr == SFR_PTR_A_LO;
        pa_if.wr_hi = sfr_wr && sfr_addr == SFR_PTR_A_HI;
        pa_if.wdata = {sfr_wdata, sfr_wdata};
        pb_if.wr_lo = sfr_wr && sfr_addr == SFR_PTR_B_LO;
        pb_if.wr_hi = sfr_wr && sfr_addr == SFR_PTR_B_HI;
        pb_if.wdata = {sfr_wdata, sfr_wdata};
        if (dp_wr && !sel_reg[SEL_PTR]) begin
            pa_if.wr_lo = 1'b1;
            pa_if.wr_hi = 1'b1;
            pa_if.wdata = dp_wdata;
        end
        if (dp_wr && sel_reg[SEL_PTR]) begin
            pb_if.wr_lo = 1'b1;
            pb_if.wr_hi = 1'b1;
            pb_if.wdata = dp_wdata;
        end
    end

    assign ptr_a = pa_if.value;
    assign ptr_b = pb_if.value;
    assign ptr_sel = sel_reg[SEL_PTR];

    // -----------------------------------------------------------------
    // Control registers and status word
    // -----------------------------------------------------------------
    assign psw_sw_wr = (sfr_wr || sfr_bit_wr) && sfr_addr == SFR_PSW;

    // Arbiter control, pointer select and status word updates
    always_comb begin
        next_arb_ctrl = arb_ctrl;
        next_sel_reg = sel_reg;
        next_psw = program_status_word;
        if (sfr_wr && sfr_addr == SFR_ARB_CTRL) begin
            next_arb_ctrl = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == SFR_PTR_SEL) begin
            next_sel_reg = sfr_wdata;
        end
        // RULE9: carry from arithmetic result
        // RULE10: half carry from nibble
        // RULE11: overflow from arithmetic
        if (alu_upd) begin
            if (alu_upd_cy) begin
                next_psw[PSW_CARRY] = alu_cy;
            end
            if (alu_upd_ac) begin
                next_psw[PSW_HALF] = alu_ac;
            end
            if (alu_upd_ov) begin
                next_psw[PSW_OVF] = alu_ov;
            end
        end
        // RULE8: byte and single-bit writes
        // RULE15: software write overrides flags
        if (sfr_wr && sfr_addr == SFR_PSW) begin
            next_psw = sfr_wdata;
        end else if (sfr_bit_wr && sfr_addr == SFR_PSW) begin
            next_psw[sfr_bit_idx] = sfr_bit_val;
        end
        // RULE13: parity of accumulator
        // RULE14: accumulator feeds parity
        // RULE16: parity recomputed every cycle
        next_psw[PSW_PARITY] = ^acc_value;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arb_ctrl <= ARB_RESET;
            sel_reg <= SEL_RESET;
            program_status_word <= PSW_RESET;
        end else begin
            arb_ctrl <= next_arb_ctrl;
            sel_reg <= next_sel_reg;
            program_status_word <= next_psw;
        end
    end

    // -----------------------------------------------------------------
    // Flash cache and prefetch controls
    // -----------------------------------------------------------------
    // Invalidate pulse on turning the cache off, prefetch on last byte
    always_comb begin
        // RULE1: invalidate when cache is turned off
        next_cache_invalidate = next_arb_ctrl[ARB_CACHE_OFF] && !arb_ctrl[ARB_CACHE_OFF];
        // RULE2: request next two bytes
        next_prefetch_req = fetch_last_byte && !arb_ctrl[ARB_PREF_OFF];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cache_off <= ARB_RESET[ARB_CACHE_OFF];
            prefetch_off <= ARB_RESET[ARB_PREF_OFF];
            cache_invalidate <= 1'b0;
            prefetch_req <= 1'b0;
        end else begin
            cache_off <= next_arb_ctrl[ARB_CACHE_OFF];
            prefetch_off <= next_arb_ctrl[ARB_PREF_OFF];
            cache_invalidate <= next_cache_invalidate;
            prefetch_req <= next_prefetch_req;
        end
    end

    // -----------------------------------------------------------------
    // Register read
    // -----------------------------------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        next_sfr_rdata = sfr_rdata;
        if (sfr_rd) begin
            unique case (sfr_addr)
                SFR_PTR_A_LO: next_sfr_rdata = pa_if.value[7:0];
                SFR_PTR_A_HI: next_sfr_rdata = pa_if.value[15:8];
                SFR_PTR_B_LO: next_sfr_rdata = pb_if.value[7:0];
                SFR_PTR_B_HI: next_sfr_rdata = pb_if.value[15:8];
                SFR_PTR_SEL: next_sfr_rdata = sel_reg;
                SFR_ARB_CTRL: next_sfr_rdata = arb_ctrl;
                SFR_PSW: next_sfr_rdata = program_status_word;
                default: next_sfr_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // -----------------------------------------------------------------
    // General register banks
    // -----------------------------------------------------------------
    csp_bank_ram #(
        .DEPTH(BANK_COUNT * BANK_REGS),
        .AW(5)
    ) u_banks (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr_a(gp_idx),
        .rdata_a(ram_gp_q),
        .raddr_b(rn_addr),
        .rdata_b(ram_rn_q)
    );

    // RULE5: data-space window
    // RULE6: unified-space alias
    always_comb begin
        gp_idx = gp_addr[4:0];
        if (gp_uni) begin
            gp_in_range = gp_addr >= BANK_UNI_BASE && gp_addr <= BANK_UNI_LAST;
        end else begin
            gp_in_range = gp_addr >= BANK_DATA_BASE && gp_addr <= BANK_DATA_LAST;
        end
    end

    // RULE7: bank field picks register group
    assign rn_addr = {program_status_word[PSW_BANK_HI:PSW_BANK_LO], rn_idx};

    // Datapath access wins the write port over memory access
    always_comb begin
        ram_we = 1'b0;
        ram_waddr = gp_idx;
        ram_wdata = gp_wdata;
        if (rn_req && rn_wr) begin
            ram_we = 1'b1;
            ram_waddr = rn_addr;
            ram_wdata = rn_wdata;
        end else if (gp_req && gp_wr && gp_in_range) begin
            ram_we = 1'b1;
        end
        next_gp_hit = gp_req && gp_in_range;
        next_gp_rdata = gp_rdata;
        if (gp_req && !gp_wr) begin
            next_gp_rdata = gp_in_range ? ram_gp_q : 8'h00;
        end
        next_rn_rdata = rn_rdata;
        if (rn_req && !rn_wr) begin
            next_rn_rdata = ram_rn_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gp_rdata <= 8'h00;
            gp_hit <= 1'b0;
            rn_rdata <= 8'h00;
        end else begin
            gp_rdata <= next_gp_rdata;
            gp_hit <= next_gp_hit;
            rn_rdata <= next_rn_rdata;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_data_wr;
        gp_req && gp_wr && !gp_uni && gp_addr <= BANK_DATA_LAST && !rn_req;
    endsequence

    sequence s_alias_rd;
        gp_req && !gp_wr && gp_uni && gp_addr == (BANK_UNI_BASE | $past(gp_addr));
    endsequence

    property p_cache_inv;
        $rose(cache_off) |-> cache_invalidate && !$past(cache_invalidate);
    endproperty
    a_cache_inv: assert property (p_cache_inv) // RULE1
        else $error("cache invalidate not tied to cache turning off");

    property p_prefetch;
        fetch_last_byte && !prefetch_off |=> prefetch_req;
    endproperty
    a_prefetch: assert property (p_prefetch) // RULE2
        else $error("prefetch missing after last cached byte");

    property p_prefetch_off;
        prefetch_off && !$rose(prefetch_off) |=> !prefetch_req;
    endproperty
    a_prefetch_off: assert property (p_prefetch_off) // RULE2
        else $error("prefetch issued while disabled");

    property p_ptr_route;
        dp_wr && !sfr_wr |=> (ptr_sel ? ptr_b : ptr_a) == $past(dp_wdata);
    endproperty
    a_ptr_route: assert property (p_ptr_route) // RULE4
        else $error("pointer update went to wrong pointer");

    property p_alias;
        s_data_wr ##1 s_alias_rd |=> gp_rdata == $past(gp_wdata, 2);
    endproperty
    a_alias: assert property (p_alias) // RULE6
        else $error("unified alias does not match data-space write");

    property p_carry;
        alu_upd && alu_upd_cy && !psw_sw_wr |=> program_status_word[PSW_CARRY] == $past(alu_cy);
    endproperty
    a_carry: assert property (p_carry) // RULE9
        else $error("carry flag not taken from arithmetic");

    property p_overflow;
        alu_upd && alu_upd_ov && !psw_sw_wr |=> program_status_word[PSW_OVF] == $past(alu_ov);
    endproperty
    a_overflow: assert property (p_overflow) // RULE11
        else $error("overflow flag not taken from arithmetic");

    property p_user;
        !psw_sw_wr |=> $stable(program_status_word[PSW_USER_A]) && $stable(program_status_word[PSW_USER_B]);
    endproperty
    a_user: assert property (p_user) // RULE12
        else $error("user flag changed without software write");

    property p_parity;
        1'b1 |=> program_status_word[PSW_PARITY] == ^$past(acc_value);
    endproperty
    a_parity: assert property (p_parity) // RULE13
        else $error("parity flag does not follow accumulator");
endmodule

/* File: dv/csp_dp_model.sv */
// Behavioural model of the execution datapath beside the register block.
// Assumes one shared ref_clk; after the time-zero idle levels, every change lands on its falling edge.
`timescale 1ns/1ps
module csp_dp_model (
    input wire logic ref_clk,
    output logic alu_upd,
    output logic alu_upd_cy,
    output logic alu_upd_ac,
    output logic alu_upd_ov,
    output logic alu_cy,
    output logic alu_ac,
    output logic alu_ov,
    output logic [7:0] acc_value,
    output logic dp_wr,
    output logic [15:0] dp_wdata,
    output logic fetch_last_byte
);
    // Idle levels from time zero
    initial begin
        {alu_upd, alu_upd_cy, alu_upd_ac, alu_upd_ov} = 4'h0;
        {alu_cy, alu_ac, alu_ov, dp_wr, fetch_last_byte} = 5'h00;
        acc_value = 8'h00;
        dp_wdata = 16'h0000;
    end

    // One flag update, enables ordered carry, half carry, overflow
    task automatic flags(input logic [2:0] en, input logic [2:0] v);
        @(negedge ref_clk);
        alu_upd = 1'b1;
        {alu_upd_cy, alu_upd_ac, alu_upd_ov} = en;
        {alu_cy, alu_ac, alu_ov} = v;
        @(negedge ref_clk);
        alu_upd = 1'b0;
        {alu_upd_cy, alu_upd_ac, alu_upd_ov} = 3'h0;
        {alu_cy, alu_ac, alu_ov} = ~v;
    endtask

    task automatic set_acc(input logic [7:0] v);
        @(negedge ref_clk);
        acc_value = v;
    endtask

    // Whole pointer load, data scrambled once released
    task automatic load_ptr(input logic [15:0] v);
        @(negedge ref_clk);
        dp_wr = 1'b1;
        dp_wdata = v;
        @(negedge ref_clk);
        dp_wr = 1'b0;
        dp_wdata = ~v;
    endtask

    // Last cached byte consumed
    task automatic last_byte;
        @(negedge ref_clk);
        fetch_last_byte = 1'b1;
        @(negedge ref_clk);
        fetch_last_byte = 1'b0;
    endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the status, pointer and bank register block.
// Assumes csp_pkg, csp_ptr_if, the design modules and csp_dp_model compile first.
`timescale 1ns/1ps
module testbench
    import csp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, gp_wdata = 8'h00, rn_wdata = 8'h00;
    logic [2:0] sfr_bit_idx = 3'h0, rn_idx = 3'h0;
    logic gp_req = 1'b0, gp_uni = 1'b0, gp_wr = 1'b0, rn_req = 1'b0, rn_wr = 1'b0;
    logic [15:0] gp_addr = 16'h0000;
    logic [7:0] sfr_rdata, gp_rdata, rn_rdata, acc_value, program_status_word;
    logic [15:0] dp_wdata, ptr_a, ptr_b;
    logic alu_upd, alu_upd_cy, alu_upd_ac, alu_upd_ov, alu_cy, alu_ac, alu_ov, dp_wr;
    logic fetch_last_byte, ptr_sel, gp_hit, cache_off, prefetch_off, cache_invalidate;
    logic prefetch_req;
    int error_cnt = 0;
    int checks_done = 0;

    // Core clock, 4 ns period
    always #2 ref_clk = ~ref_clk;

    csp_regs i_dut (.ref_clk, .rst_n, .sfr_wr, .sfr_rd, .sfr_bit_wr, .sfr_addr, .sfr_bit_idx,
        .sfr_bit_val, .sfr_wdata, .sfr_rdata, .alu_upd, .alu_upd_cy, .alu_upd_ac, .alu_upd_ov,
        .alu_cy, .alu_ac, .alu_ov, .acc_value, .dp_wr, .dp_wdata, .ptr_a, .ptr_b, .ptr_sel,
        .program_status_word, .gp_req, .gp_uni, .gp_wr, .gp_addr, .gp_wdata, .gp_rdata, .gp_hit, .rn_req,
        .rn_wr, .rn_idx, .rn_wdata, .rn_rdata, .fetch_last_byte, .cache_off, .prefetch_off,
        .cache_invalidate, .prefetch_req);

    csp_dp_model i_dp (.ref_clk, .alu_upd, .alu_upd_cy, .alu_upd_ac, .alu_upd_ov, .alu_cy,
        .alu_ac, .alu_ov, .acc_value, .dp_wr, .dp_wdata, .fetch_last_byte);

    // -----------------------------------------------------------------
    // Access tasks and reporting
    // -----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out;
        $display("mismatches %0d, checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic sfrw(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        sfr_wdata = ~d;
    endtask

    task automatic sfrr(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        {sfr_rd, sfr_addr} = {1'b1, a};
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic bitw(input logic [2:0] i, input logic v);
        @(negedge ref_clk);
        {sfr_bit_wr, sfr_addr, sfr_bit_idx, sfr_bit_val} = {1'b1, SFR_PSW, i, v};
        @(negedge ref_clk);
        sfr_bit_wr = 1'b0;
        sfr_bit_val = ~v;
    endtask

    task automatic gp(input logic u, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {gp_req, gp_uni, gp_wr, gp_addr, gp_wdata} = {1'b1, u, w, a, d};
        @(negedge ref_clk);
        gp_req = 1'b0;
        gp_wdata = ~d;
    endtask

    task automatic rn(input logic w, input logic [2:0] i, input logic [7:0] d);
        @(negedge ref_clk);
        {rn_req, rn_wr, rn_idx, rn_wdata} = {1'b1, w, i, d};
        @(negedge ref_clk);
        rn_req = 1'b0;
        rn_wdata = ~d;
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] ra [8] = '{SFR_PTR_A_LO, SFR_PTR_A_HI, SFR_PTR_B_LO, SFR_PTR_B_HI,
            SFR_PTR_SEL, SFR_ARB_CTRL, SFR_PSW, 8'h80};
        logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        logic [7:0] d;
        check(ptr_a, 16'h0000, "ptr_a");
        check(ptr_b, 16'h0000, "ptr_b");
        check({4'h0, cache_off, prefetch_off, ptr_sel, cache_invalidate, program_status_word}, 16'h0400,
            "levels");
        sfrw(8'h80, 8'hFF);
        foreach (ra[i]) begin
            sfrr(ra[i], d);
            check({8'h00, d}, {8'h00, rv[i]}, "reset read");
        end
    endtask

    task automatic t_ptrs;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            sfrw(SFR_PTR_A_LO + 8'(i), 8'h11 * 8'(i + 1));
        end
        check(ptr_a, 16'h2211, "ptr_a bytes");
        check(ptr_b, 16'h4433, "ptr_b bytes");
        sfrr(SFR_PTR_B_HI, d);
        check({8'h00, d}, 16'h0044, "ptr read");
        i_dp.load_ptr(16'hBEEF);
        check(ptr_a, 16'hBEEF, "load a");
        check(ptr_b, 16'h4433, "keep b");
        sfrw(SFR_PTR_SEL, 8'hFF);
        check({15'h0, ptr_sel}, 16'h0001, "select");
        i_dp.load_ptr(16'h1234);
        check(ptr_b, 16'h1234, "load b");
        check(ptr_a, 16'hBEEF, "keep a");
        sfrr(SFR_PTR_SEL, d);
        check({8'h00, d}, 16'h00FF, "select read");
        sfrw(SFR_PTR_SEL, 8'hFE);
        check({15'h0, ptr_sel}, 16'h0000, "select 0");
    endtask

    task automatic t_arb;
        logic [7:0] d;
        sfrw(SFR_ARB_CTRL, 8'h02);
        check({13'h0, cache_off, cache_invalidate, prefetch_off}, 16'h0006, "cache off");
        @(negedge ref_clk);
        check({15'h0, cache_invalidate}, 16'h0000, "inval pulse");
        i_dp.last_byte();
        check({15'h0, prefetch_req}, 16'h0001, "prefetch");
        @(negedge ref_clk);
        check({15'h0, prefetch_req}, 16'h0000, "prefetch pulse");
        sfrw(SFR_ARB_CTRL, 8'h03);
        check({13'h0, cache_off, cache_invalidate, prefetch_off}, 16'h0005, "no inval");
        i_dp.last_byte();
        check({15'h0, prefetch_req}, 16'h0000, "prefetch off");
        sfrw(SFR_ARB_CTRL, 8'hFC);
        sfrr(SFR_ARB_CTRL, d);
        check({6'h0, cache_off, prefetch_off, d}, 16'h00FC, "arb read");
    endtask

    task automatic t_banks;
        logic [7:0] a;
        for (int b = 0; b < 4; b++) begin
            a = 8'(b * 8 + b + 2);
            bitw(3'h3, b[0]);
            bitw(3'h4, b[1]);
            check({14'h0, program_status_word[4:3]}, 16'(b), "bank");
            rn(1'b1, 3'(b + 2), 8'hA0 ^ a);
            gp(1'b0, 1'b0, {8'h00, a}, 8'h00);
            check({gp_hit, 7'h0, gp_rdata}, {1'b1, 7'h0, 8'hA0 ^ a}, "data");
            gp(1'b1, 1'b0, {8'hFF, a}, 8'h00);
            check({gp_hit, 7'h0, gp_rdata}, {1'b1, 7'h0, 8'hA0 ^ a}, "unified");
            gp(1'b1, 1'b1, {8'hFF, a + 8'h05 - 8'(b)}, ~a);
            rn(1'b0, 3'h7, 8'h00);
            check({8'h00, rn_rdata}, {8'h00, ~a}, "alias");
        end
        // data write, alias read next cycle
        @(negedge ref_clk);
        {gp_req, gp_uni, gp_wr, gp_addr, gp_wdata} = {1'b1, 1'b0, 1'b1, 16'h0009, 8'h5A};
        @(negedge ref_clk);
        {gp_uni, gp_wr, gp_addr} = {1'b1, 1'b0, 16'hFF09};
        @(negedge ref_clk);
        gp_req = 1'b0;
        check({gp_hit, 7'h0, gp_rdata}, 16'h805A, "back to back");
        gp(1'b0, 1'b1, 16'h0020, 8'h77);
        gp(1'b0, 1'b0, 16'h0000, 8'h00);
        check({gp_hit, 7'h0, gp_rdata}, 16'h8000, "no wrap");
        gp(1'b1, 1'b0, 16'hFE1F, 8'h00);
        check({gp_hit, 7'h0, gp_rdata}, 16'h0000, "outside");
    endtask

    task automatic t_flags;
        int pos [3] = '{7, 6, 2};
        logic [7:0] acc [5] = '{8'h01, 8'h03, 8'h80, 8'hFF, 8'h7E};
        bitw(3'h5, 1'b1);
        bitw(3'h1, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i_dp.flags(3'b100 >> i, 3'b111);
            check({15'h0, program_status_word[pos[i]]}, 16'h0001, "flag set");
            i_dp.flags(3'b100 >> i, 3'b000);
            check({15'h0, program_status_word[pos[i]]}, 16'h0000, "flag clear");
        end
        i_dp.flags(3'b111, 3'b101);
        check({8'h00, program_status_word}, 16'h00BE, "all flags");
        bitw(3'h7, 1'b0);
        check({15'h0, program_status_word[7]}, 16'h0000, "bit write");
        sfrw(SFR_PSW, 8'h45);
        check({8'h00, program_status_word}, 16'h0044, "byte write");
        foreach (acc[k]) begin
            i_dp.set_acc(acc[k]);
            @(negedge ref_clk);
            check({15'h0, program_status_word[0]}, {15'h0, ^acc[k]}, "parity");
            bitw(3'h0, ~^acc[k]);
            check({15'h0, program_status_word[0]}, {15'h0, ^acc[k]}, "parity kept");
        end
    endtask

    // -----------------------------------------------------------------
    // Main sequence and hang guard
    // -----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_ptrs();
        t_arb();
        t_banks();
        t_flags();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        close_out();
    end
endmodule
